/* File: bdp_lamp_model.sv */
// far-side model: lamp strings and the ignition rc timer
`timescale 1ns/100ps
module bdp_lamp_model
#(
    parameter int MASK_CLKS = 200
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // from the device
    input wire logic lamp_drive_i,
    input wire logic discharge_i,
    // scenario control
    input wire logic open_lamp_i,
    // to the device
    output logic lamp_current_ok_o,
    output logic timer_o
);
    int charge_q;
    // unlit strings carry no current, so ok is low outside drive time
    assign lamp_current_ok_o = lamp_drive_i & ~open_lamp_i;
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            charge_q <= 0;
        else if (discharge_i)
            charge_q <= 0;
        else if (charge_q < MASK_CLKS)
            charge_q <= charge_q + 1;
    end
    assign timer_o = (charge_q >= MASK_CLKS);
endmodule

/* File: bdp_ramp.sv */
// shared constants and types, and the dual-slope dimming ramp counter
package bdp_pkg;
    localparam int RAMP_W = 8;
    localparam int LEVEL_W = 9;
    localparam logic [RAMP_W-1:0] RAMP_MIN = 8'h00;
    localparam logic [RAMP_W-1:0] RAMP_MAX = 8'hff;
    localparam logic [RAMP_W-1:0] FLOOR_COUNT = 8'h08;
    localparam logic [LEVEL_W-1:0] LEVEL_FULL = 9'h100;
    // 12.5 % of a 512-count period is 64 on-counts, i.e. level 32
    localparam logic [LEVEL_W-1:0] LOW_DUTY_LEVEL = 9'h020;
    localparam logic [5:0] BLANK_COUNTS = 6'h30;
    localparam int PERIOD_COUNTS = 512;
    localparam int CLK_HZ = 20000000;
    // nominal timebase: 250 Hz burst times 512 counts
    localparam int OSC_HZ = 128000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int DIV_W = 16;

    typedef struct packed {
        logic [RAMP_W-1:0] count;
        logic down;
    } bdp_ramp_type;

    typedef enum logic [1:0] {
        IGN_HOLD = 2'b00,
        IGN_MASK = 2'b01,
        IGN_DONE = 2'b10
    } bdp_ign_type;
endpackage

`timescale 1ns/100ps
module bdp_ramp
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // timebase count
    input wire logic tick_i,
    // ramp state
    output bdp_pkg::bdp_ramp_type ramp_o
);
    bdp_pkg::bdp_ramp_type ramp_q;
    logic [9:0] period_q;

    assign ramp_o = ramp_q;

    // each end value is held for two counts so up plus down is 512 counts
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ramp_q <= '0;
        end
        else if (tick_i)
        begin
            if (!ramp_q.down)
            begin
                if (ramp_q.count == bdp_pkg::RAMP_MAX)
                    ramp_q.down <= 1'b1;
                else
                    ramp_q.count <= ramp_q.count + 8'h01;
            end
            else
            begin
                if (ramp_q.count == bdp_pkg::RAMP_MIN)
                    ramp_q.down <= 1'b0;
                else
                    ramp_q.count <= ramp_q.count - 8'h01;
            end
        end
    end

    // helper: counts ticks within one period, for checking only
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            period_q <= 10'h000;
        else if (tick_i)
            period_q <= (ramp_q.down && ramp_q.count == bdp_pkg::RAMP_MIN) ? 10'h000 : period_q + 10'h001;
    end

    turn_top_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tick_i && !ramp_q.down && ramp_q.count == bdp_pkg::RAMP_MAX |=> ramp_q.down && ramp_q.count == bdp_pkg::RAMP_MAX)
        else $error("ramp did not turn at top");
    period_len_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tick_i && ramp_q.down && ramp_q.count == bdp_pkg::RAMP_MIN |-> period_q == 10'(bdp_pkg::PERIOD_COUNTS - 1))
        else $error("ramp period is not 512 counts");
endmodule

/* File: bdp_top.sv */
// burst dimming pwm with ignition mask and open-lamp fault latch
`timescale 1ns/100ps
module bdp_top
#(
    parameter int OSC_DIV = bdp_pkg::OSC_DIV
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // timebase
    input wire logic ext_timebase_sel_i,
    input wire logic burst_timebase_in_i,
    // control
    input wire logic enable_i,
    input wire logic uvlo_i,
    input wire logic [bdp_pkg::LEVEL_W-1:0] brightness_level_i,
    // lamp sensing and ignition timer
    input wire logic lamp_current_ok_i,
    input wire logic ignition_mask_timer_i,
    // outputs
    output logic lamp_drive_o,
    output logic fault_o,
    output logic ignition_done_o,
    output logic ignition_discharge_o
);
    logic [bdp_pkg::DIV_W-1:0] div_q;
    logic ext_prev_q;
    logic tick_q;
    bdp_pkg::bdp_ramp_type ramp;
    logic active;
    logic drive_q;
    logic [5:0] blank_q;
    logic blank_done;
    logic sample_ok;
    logic fault_set;
    logic fault_q;
    bdp_pkg::bdp_ign_type ign_q;
    bdp_pkg::bdp_ign_type ign_d;
    logic done_q;
    logic discharge_q;

    assign lamp_drive_o = drive_q;
    assign fault_o = fault_q;
    assign ignition_done_o = done_q;
    assign ignition_discharge_o = discharge_q;

    // enable low or undervoltage act as a level reset of the lamp logic
    assign active = enable_i && !uvlo_i;

    // internal timebase divider
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            div_q <= '0;
        else if (div_q == bdp_pkg::DIV_W'(OSC_DIV - 1))
            div_q <= '0;
        else
            div_q <= div_q + 16'h0001;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            ext_prev_q <= 1'b0;
        else
            ext_prev_q <= burst_timebase_in_i;
    end

    // one tick per timebase count; external rising edges replace the divider
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            tick_q <= 1'b0;
        else if (ext_timebase_sel_i)
            tick_q <= burst_timebase_in_i && !ext_prev_q;
        else
            tick_q <= (div_q == bdp_pkg::DIV_W'(OSC_DIV - 1));
    end

    tick_int_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !ext_timebase_sel_i && div_q == bdp_pkg::DIV_W'(OSC_DIV - 1) |=> tick_q)
        else $error("divider wrap gave no count");
    int_quiet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !ext_timebase_sel_i && div_q != bdp_pkg::DIV_W'(OSC_DIV - 1) |=> !tick_q)
        else $error("internal count off the divider wrap");
    ext_quiet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ext_timebase_sel_i && !(burst_timebase_in_i && !ext_prev_q) |=> !tick_q)
        else $error("external count without a rising edge");

    bdp_ramp u_ramp
    (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick_q),
        .ramp_o(ramp)
    );

    // compare once per count; level is 9 bits so full scale 256 never loses
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            drive_q <= 1'b0;
        else if (!active || fault_q || fault_set)
            drive_q <= 1'b0;
        else if (tick_q)
            drive_q <= (ramp.count < bdp_pkg::FLOOR_COUNT)
                || (brightness_level_i > {1'b0, ramp.count});
    end

    // drive may only move on a count or a shutdown
    drive_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !tick_q && active && !fault_q && !fault_set |=> $stable(drive_q))
        else $error("drive changed between counts");

    // blanking after the rising edge of drive, counted in ramp counts
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            blank_q <= '0;
        else if (!drive_q)
            blank_q <= '0;
        else if (tick_q && !blank_done)
            blank_q <= blank_q + 6'h01;
    end

    assign blank_done = (blank_q == bdp_pkg::BLANK_COUNTS);

    // blanking restarts on every rise, so a short run never samples
    blank_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !drive_q |=> blank_q == 6'h00)
        else $error("blanking not restarted while drive low");
    blank_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        drive_q && tick_q && !blank_done |=> blank_q == $past(blank_q) + 6'h01)
        else $error("blanking missed a count");
    blank_limit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        blank_q <= bdp_pkg::BLANK_COUNTS)
        else $error("blanking counter overran");
    rise_blank_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(drive_q) |-> blank_q == 6'h00)
        else $error("drive rose with blanking already counted");

    // sensing needs drive high, blanking over, ignition done and duty high enough
    assign sample_ok = tick_q && drive_q && blank_done
        && done_q
        && (brightness_level_i >= bdp_pkg::LOW_DUTY_LEVEL);
    assign fault_set = active && sample_ok && !lamp_current_ok_i;

    // enable or undervoltage clear wins: it is a reset level, not an event clear
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            fault_q <= 1'b0;
        else if (!active)
            fault_q <= 1'b0;
        else if (fault_set)
            fault_q <= 1'b1;
    end

    fault_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fault_set |=> fault_q && !drive_q)
        else $error("valid dark sample did not shut down");

    always_comb
    begin
        ign_d = ign_q;
        if (!active)
            ign_d = bdp_pkg::IGN_HOLD;
        else
        begin
            unique case (ign_q)
                bdp_pkg::IGN_HOLD:
                begin
                    ign_d = bdp_pkg::IGN_MASK;
                end
                bdp_pkg::IGN_MASK:
                begin
                    if (ignition_mask_timer_i)
                        ign_d = bdp_pkg::IGN_DONE;
                end
                bdp_pkg::IGN_DONE:
                begin
                    ign_d = bdp_pkg::IGN_DONE;
                end
                default:
                begin
                    ign_d = bdp_pkg::IGN_HOLD;
                end
            endcase
        end
    end

    // power-up starts the mask interval like an enable rise
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            ign_q <= bdp_pkg::IGN_HOLD;
        else
            ign_q <= ign_d;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            done_q <= 1'b0;
        else
            done_q <= (ign_d == bdp_pkg::IGN_DONE);
    end

    // timer held discharged while disabled and once the interval has ended
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            discharge_q <= 1'b1;
        else
            discharge_q <= (ign_d != bdp_pkg::IGN_MASK);
    end

    ign_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        active && ign_q == bdp_pkg::IGN_MASK && !ignition_mask_timer_i |=> ign_q == bdp_pkg::IGN_MASK && !done_q)
        else $error("ignition interval ended early");
    done_stay_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        done_q && active |=> done_q)
        else $error("interval done state lost");
    hold_state_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !active |=> ign_q == bdp_pkg::IGN_HOLD)
        else $error("ignition state not held while off");

    ext_tick_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ext_timebase_sel_i && burst_timebase_in_i && !ext_prev_q |=> tick_q)
        else $error("external edge gave no count");
    floor_high_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tick_q && active && !fault_q && !fault_set && ramp.count < bdp_pkg::FLOOR_COUNT |=> drive_q)
        else $error("floor did not force drive high");
    compare_high_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tick_q && active && !fault_q && !fault_set && brightness_level_i > {1'b0, ramp.count} |=> drive_q)
        else $error("level above count but drive low");
    compare_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tick_q && ramp.count >= bdp_pkg::FLOOR_COUNT && brightness_level_i <= {1'b0, ramp.count} |=> !drive_q)
        else $error("drive high above level");
    full_scale_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        active && !fault_q && !fault_set && tick_q && brightness_level_i >= bdp_pkg::LEVEL_FULL |=> drive_q)
        else $error("full scale not 100 percent");
    disable_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !enable_i |=> !drive_q && !fault_q && discharge_q && !done_q)
        else $error("enable low did not reset lamp logic");
    uvlo_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        uvlo_i |=> !drive_q && !fault_q && !done_q)
        else $error("undervoltage did not reset lamp logic");
    fault_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fault_q |-> !drive_q)
        else $error("drive high during fault");
    fault_cause_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(fault_q) |-> $past(drive_q) && !$past(lamp_current_ok_i) && $past(tick_q))
        else $error("fault without valid sample");
    fault_blank_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(fault_q) |-> $past(blank_q) == bdp_pkg::BLANK_COUNTS)
        else $error("fault inside blanking");
    fault_mask_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(fault_q) |-> $past(done_q))
        else $error("fault during ignition interval");
    low_duty_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(fault_q) |-> $past(brightness_level_i) >= bdp_pkg::LOW_DUTY_LEVEL)
        else $error("fault at low duty");
    fault_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fault_q && active |=> fault_q)
        else $error("fault latch released");
    ign_restart_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(active) |=> ign_q == bdp_pkg::IGN_MASK ##1 !discharge_q || !active)
        else $error("enable rise did not restart interval");
    ign_done_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        active && ign_q == bdp_pkg::IGN_MASK && ignition_mask_timer_i |=> done_q && discharge_q)
        else $error("interval end not latched and discharged");

    fault_seen_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(fault_q));
    ign_end_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(done_q));
    ext_drive_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        ext_timebase_sel_i && $rose(drive_q));
    enable_cycle_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        fault_q ##1 !enable_i ##1 enable_i);
    restart_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        uvlo_i ##1 !uvlo_i);
endmodule

/* File: tb.sv */
// self-checking bench for the burst dimming pwm
`timescale 1ns/100ps
`define CHK(a, b, m) \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
        bad_count++; \
        $display("BAD t=%0t %s", $time, m); \
    end
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ext_sel = 1'b0;
    logic [2:0] ext_div = 3'h0;
    logic enable = 1'b1;
    logic uvlo = 1'b0;
    logic [8:0] level = 9'h000;
    logic open_lamp = 1'b0;
    logic ok, timer, drive, fault, done, dis;
    int bad_count = 0;
    int n_tests = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    // external pulse train, 8 clk per count
    always @(posedge clk_sys_i) ext_div <= #1 ext_div + 3'h1;
    bdp_top #(.OSC_DIV(2)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ext_timebase_sel_i(ext_sel),
        .burst_timebase_in_i(ext_div[2]), .enable_i(enable), .uvlo_i(uvlo), .brightness_level_i(level),
        .lamp_current_ok_i(ok), .ignition_mask_timer_i(timer), .lamp_drive_o(drive), .fault_o(fault),
        .ignition_done_o(done), .ignition_discharge_o(dis));
    bdp_lamp_model #(.MASK_CLKS(200)) lamp_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .lamp_drive_i(drive),
        .discharge_i(dis), .open_lamp_i(open_lamp), .lamp_current_ok_o(ok), .timer_o(timer));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_fault(input int n);
        for (int i = 0; i < n && fault !== 1'b1; i++) step(1);
    endtask
    // counts drive-high clocks over one full burst period
    task automatic t_duty(input logic [8:0] lv, input logic ex, input int per, input logic [15:0] exp_hi);
        logic [15:0] hi;
        hi = 16'h0000;
        level = lv;
        ext_sel = ex;
        step(per + 200);
        repeat (per)
        begin
            step(1);
            if (drive === 1'b1) hi++;
        end
        `CHK(hi, exp_hi, "on time over one period")
        `CHK(fault, 1'b0, "fault from low-time sampling")
        $display("duty test level %0d ext %0d done", lv, ex);
    endtask
    // enable cycle with an open lamp present during ignition
    task automatic t_ignition;
        open_lamp = 1'b1;
        level = 9'h100;
        enable = 1'b0;
        step(2);
        `CHK({drive, fault, done, dis}, 4'b0001, "enable low state")
        enable = 1'b1;
        step(2);
        `CHK(dis, 1'b0, "timer not released")
        step(100);
        `CHK({fault, done}, 2'b00, "fault during ignition")
        for (int i = 0; i < 300 && done !== 1'b1; i++) step(1);
        `CHK({done, dis}, 2'b11, "ignition end")
        wait_fault(2100);
        step(1);
        `CHK({fault, drive}, 2'b10, "open lamp after ignition")
        open_lamp = 1'b0;
        enable = 1'b0;
        step(2);
        `CHK(fault, 1'b0, "fault not cleared")
        enable = 1'b1;
        step(300);
        $display("ignition test done");
    endtask
    // duty threshold boundary, latch hold and lockout
    task automatic t_fault;
        logic [15:0] hi;
        hi = 16'h0000;
        open_lamp = 1'b1;
        level = 9'h01f;
        step(3000);
        `CHK(fault, 1'b0, "fault at low duty")
        // open the lamp in a drive gap: 48 blanked counts, sample on the next, 2 clk per count
        open_lamp = 1'b0;
        level = 9'h020;
        for (int i = 0; i < 1100 && drive !== 1'b0; i++) step(1);
        open_lamp = 1'b1;
        for (int i = 0; i < 1100 && drive !== 1'b1; i++) step(1);
        for (int i = 0; i < 300 && fault !== 1'b1; i++)
        begin
            if (drive === 1'b1) hi++;
            step(1);
        end
        `CHK(fault, 1'b1, "no fault at threshold duty")
        `CHK(hi, 16'((bdp_pkg::BLANK_COUNTS + 1) * 2), "blanking length")
        open_lamp = 1'b0;
        step(1100);
        `CHK({fault, drive}, 2'b10, "latch lost")
        uvlo = 1'b1;
        step(2);
        `CHK({drive, fault, done, dis}, 4'b0001, "lockout state")
        uvlo = 1'b0;
        step(2);
        `CHK(dis, 1'b0, "restart after lockout")
        $display("fault test done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #4000000;
        bad_count++;
        $display("BAD t=%0t watchdog expired", $time);
        conclude();
    end
    initial
    begin
        step(3);
        `CHK({drive, fault, done, dis}, 4'b0001, "reset values")
        rst_i = 1'b0;
        step(2);
        `CHK(dis, 1'b0, "timer not released after reset")
        t_ignition();
        t_duty(9'h000, 1'b0, 1024, 16'd32);
        t_duty(9'h064, 1'b0, 1024, 16'd400);
        t_duty(9'h12c, 1'b0, 1024, 16'd1024);
        t_duty(9'h000, 1'b1, 4096, 16'd128);
        ext_sel = 1'b0;
        t_fault();
        conclude();
    end
endmodule
